// ==== hw/dsp_io_port.sv ====
/*
  dual six-bit general purpose port with direction latches, option
  register, weak pull-ups, wake on change and status wake flag.
  assumes the core drives reg/instr strobes on the same clock, one
  strobe per instruction cycle, and pins come from outside the domain.
*/
//
// Contract
// - port reads return live pin levels, not latch contents
// - reset sets every direction bit, pins start as inputs
// - group b upper two bits read zero
// - group c upper two bits read zero
// - input-only pin never drives, its direction bit ignored
// - pins on an analog or comparator function, or serving as reset input, read zero
// - pull-up and wake only on group b bits 0,1,3,4
// - pull-up and wake enables are single global controls
// - reset-pin mode forces pull-up on and removes wake on that pin
// - direction latches load only on the direction instruction, unreadable
// - direction one puts the driver in high impedance
// - direction zero drives the output latch value
// - timer clock pin direction overridden by option config
// - inputs not latched; output latches hold until rewritten
// - each pin but input-only has its own direction bit
// - bit set/clear reads pins, modifies bit, writes whole latch
// - analog first, then peripheral, then forced timer input, then direction latch
// - status bit 7 set on pin-change wake reset, else cleared
// - writes take effect at cycle end, reads sample at start
`timescale 1ns/100ps
`include "dsp_io_defs.svh"
module dsp_io_port (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wake_reset_cause,
  input wire logic [4:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic bit_op,
  input wire logic bit_value,
  input wire logic [2:0] bit_index,
  input wire logic dir_load,
  input wire logic [2:0] dir_port_sel,
  input wire logic option_load,
  input wire logic [7:0] work_reg,
  input wire logic external_reset_enable,
  input wire logic [5:0] group_b_alt_analog,
  input wire logic [5:0] group_b_alt_comp,
  input wire logic [5:0] group_b_alt_out_en,
  input wire logic [5:0] group_b_alt_out,
  input wire logic [5:0] group_c_alt_analog,
  input wire logic [5:0] group_c_alt_out_en,
  input wire logic [5:0] group_c_alt_out,
  input wire logic [5:0] group_b_pin_bits_in,
  input wire logic [5:0] group_c_pin_bits_in,
  output logic [5:0] group_b_pin_bits_out,
  output logic [5:0] group_b_pin_bits_oe_n,
  output logic [5:0] group_c_pin_bits_out,
  output logic [5:0] group_c_pin_bits_oe_n,
  output logic [5:0] group_b_pull_up,
  output logic pin_wake_event,
  output logic [7:0] reg_rdata,
  output logic pin_wake_flag
);

  ////////////////////////////////////////////////////////////////////
  // pin sampling
  logic [5:0] b_sync;
  logic [5:0] c_sync;
  dsp_sync u_sync_b (
    .clock(clock),
    .reset_n(reset_n),
    .pins_async(group_b_pin_bits_in),
    .pins_sync(b_sync)
  );
  dsp_sync u_sync_c (
    .clock(clock),
    .reset_n(reset_n),
    .pins_async(group_c_pin_bits_in),
    .pins_sync(c_sync)
  );

  ////////////////////////////////////////////////////////////////////
  // option register, write-only
  logic [7:0] option_config;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      option_config <= `DSP_OPT_RESET;
    end else if (option_load) begin
      option_config <= work_reg;
    end
  end
  logic wake_enable;
  logic pull_enable;
  logic tmr_pin_override;
  // active-low enables, one bit each for the whole group
  assign wake_enable = ~option_config[`DSP_OPT_WAKE_N];
  assign pull_enable = ~option_config[`DSP_OPT_PULL_N];
  assign tmr_pin_override = option_config[`DSP_OPT_TMR_SRC];

  ////////////////////////////////////////////////////////////////////
  // read view, decoded once for reads and read-modify-write
  function automatic logic [7:0] port_view(input logic [5:0] pins, input logic [5:0] alt);
    port_view = {2'b00, pins & ~alt};
  endfunction

  logic [5:0] b_alt;
  logic [5:0] c_alt;
  logic [5:0] b_alt_raw;
  always_comb begin
    b_alt_raw = group_b_alt_analog | group_b_alt_comp;
    // input-only pin reads zero while it serves as the reset input
    b_alt_raw[`DSP_INPUT_ONLY_BIT] = external_reset_enable;
  end
  assign b_alt = b_alt_raw;
  assign c_alt = group_c_alt_analog;
  logic [7:0] b_view;
  logic [7:0] c_view;
  assign b_view = port_view(b_sync, b_alt);
  assign c_view = port_view(c_sync, c_alt);

  ////////////////////////////////////////////////////////////////////
  // write decode
  dsp_io_pkg::dsp_op_e op;
  logic sel_b;
  logic sel_c;
  assign sel_b = (reg_addr == `DSP_ADDR_GROUP_B);
  assign sel_c = (reg_addr == `DSP_ADDR_GROUP_C);
  always_comb begin
    if (reg_write && bit_op) begin
      op = dsp_io_pkg::DSP_OP_RMW;
    end else if (reg_write) begin
      op = dsp_io_pkg::DSP_OP_WRITE;
    end else begin
      op = dsp_io_pkg::DSP_OP_IDLE;
    end
  end

  function automatic logic [5:0] set_bit(input logic [7:0] view, input logic [2:0] idx, input logic val);
    logic [7:0] tmp;
    tmp = view;
    tmp[idx] = val;
    set_bit = tmp[5:0];
  endfunction

  logic [5:0] next_b_data;
  logic [5:0] next_c_data;
  logic b_we;
  logic c_we;
  always_comb begin
    next_b_data = reg_wdata[5:0];
    next_c_data = reg_wdata[5:0];
    b_we = 1'b0;
    c_we = 1'b0;
    case (op)
      dsp_io_pkg::DSP_OP_WRITE: begin
        b_we = sel_b;
        c_we = sel_c;
      end
      dsp_io_pkg::DSP_OP_RMW: begin
        // pins read back into every latch bit, inputs included
        next_b_data = set_bit(b_view, bit_index, bit_value);
        next_c_data = set_bit(c_view, bit_index, bit_value);
        b_we = sel_b;
        c_we = sel_c;
      end
      dsp_io_pkg::DSP_OP_IDLE: begin
        b_we = 1'b0;
        c_we = 1'b0;
      end
      default: begin
        b_we = 1'b0;
        c_we = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // latches
  logic [5:0] b_data;
  logic [5:0] b_dir;
  logic [5:0] c_data;
  logic [5:0] c_dir;
  logic b_dir_we;
  logic c_dir_we;
  assign b_dir_we = dir_load && (dir_port_sel == `DSP_PORT_SEL_B);
  assign c_dir_we = dir_load && (dir_port_sel == `DSP_PORT_SEL_C);
  dsp_port_lane u_lane_b (
    .clock(clock),
    .reset_n(reset_n),
    .data_we(b_we),
    .data_in(next_b_data),
    .dir_we(b_dir_we),
    .dir_in(work_reg[5:0]),
    .data_latch(b_data),
    .dir_latch(b_dir)
  );
  dsp_port_lane u_lane_c (
    .clock(clock),
    .reset_n(reset_n),
    .data_we(c_we),
    .data_in(next_c_data),
    .dir_we(c_dir_we),
    .dir_in(work_reg[5:0]),
    .data_latch(c_data),
    .dir_latch(c_dir)
  );

  ////////////////////////////////////////////////////////////////////
  // pin drive, precedence per pin
  wire logic [5:0] next_b_out;
  wire logic [5:0] next_b_oe_n;
  wire logic [5:0] next_c_out;
  wire logic [5:0] next_c_oe_n;

  // one pin: analog floats it, a peripheral drives it, then a forced
  // input, then the direction latch; returns {oe_n, out}
  function automatic logic [1:0] pin_drive(input logic analog, input logic per_en, input logic per_val,
    input logic force_in, input logic dir, input logic data);
    if (analog) begin
      pin_drive = 2'b10;
    end else if (per_en) begin
      pin_drive = {1'b0, per_val};
    end else if (force_in) begin
      pin_drive = 2'b10;
    end else begin
      // own direction bit per pin; one floats, zero drives latch
      pin_drive = {dir, data};
    end
  endfunction
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_drive
      if (g == `DSP_INPUT_ONLY_BIT) begin : g_in_only
        // no buffer on this pin; its direction bit is kept but never used
        assign next_b_oe_n[g] = 1'b1;
        assign next_b_out[g] = 1'b0;
      end else begin : g_b_io
        assign {next_b_oe_n[g], next_b_out[g]} = pin_drive(
          group_b_alt_analog[g],
          group_b_alt_out_en[g],
          group_b_alt_out[g],
          1'b0,
          b_dir[g],
          b_data[g]
        );
      end
      // timer source on the pin wins over the direction latch
      assign {next_c_oe_n[g], next_c_out[g]} = pin_drive(
        group_c_alt_analog[g],
        group_c_alt_out_en[g],
        group_c_alt_out[g],
        (g == `DSP_TMR_PIN_BIT) && tmr_pin_override,
        c_dir[g],
        c_data[g]
      );
    end
  endgenerate

  // registered drive: a write shows on the pin after the cycle ends
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      group_b_pin_bits_out <= 6'h00;
      group_b_pin_bits_oe_n <= 6'h3f;
      group_c_pin_bits_out <= 6'h00;
      group_c_pin_bits_oe_n <= 6'h3f;
    end else begin
      group_b_pin_bits_out <= next_b_out;
      group_b_pin_bits_oe_n <= next_b_oe_n;
      group_c_pin_bits_out <= next_c_out;
      group_c_pin_bits_oe_n <= next_c_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pull-ups and wake on change
  logic [5:0] wake_mask;
  logic [5:0] next_pull;
  always_comb begin
    wake_mask = `DSP_WAKE_PIN_MASK;
    if (external_reset_enable) begin
      wake_mask[`DSP_INPUT_ONLY_BIT] = 1'b0;
    end
    next_pull = pull_enable ? `DSP_WAKE_PIN_MASK : 6'h00;
    if (external_reset_enable) begin
      next_pull[`DSP_INPUT_ONLY_BIT] = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      group_b_pull_up <= 6'h00;
    end else begin
      group_b_pull_up <= next_pull;
    end
  end

  // reference snapshot taken on each group b read, as the core does
  logic [5:0] wake_ref;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wake_ref <= 6'h00;
    end else if (reg_read && sel_b) begin
      wake_ref <= b_sync;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_wake_event <= 1'b0;
    end else begin
      pin_wake_event <= wake_enable && |((b_sync ^ wake_ref) & wake_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status wake flag, caught after reset release from cause input
  logic flag_caught;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_caught <= 1'b0;
      pin_wake_flag <= 1'b0;
    end else if (!flag_caught) begin
      flag_caught <= 1'b1;
      pin_wake_flag <= wake_reset_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data: pins sampled at start of the cycle, no latch view
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `DSP_ADDR_GROUP_B: reg_rdata <= b_view;
        `DSP_ADDR_GROUP_C: reg_rdata <= c_view;
        `DSP_ADDR_STATUS: reg_rdata <= {pin_wake_flag, 7'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ==== shared/dsp_io_defs.svh ====
/*
  constants for the dual six-bit port block: offsets, field positions,
  reset values. assumes inclusion by bare name from design files.
*/
`ifndef DSP_IO_DEFS_SVH
`define DSP_IO_DEFS_SVH
`define DSP_ADDR_STATUS 5'h03
`define DSP_ADDR_GROUP_B 5'h06
`define DSP_ADDR_GROUP_C 5'h07
`define DSP_PORT_SEL_B 3'h6
`define DSP_PORT_SEL_C 3'h7
`define DSP_DIR_RESET 6'h3f
`define DSP_OPT_RESET 8'hff
`define DSP_OPT_WAKE_N 7
`define DSP_OPT_PULL_N 6
`define DSP_OPT_TMR_SRC 5
`define DSP_WAKE_FLAG_BIT 7
`define DSP_INPUT_ONLY_BIT 3
`define DSP_TMR_PIN_BIT 5
`define DSP_WAKE_PIN_MASK 6'h1b
`endif

// ==== shared/dsp_io_pkg.sv ====
/*
  types for the dual six-bit port block.
  assumes dsp_io_defs.svh supplies the numeric constants.
*/
package dsp_io_pkg;
  typedef logic [5:0] dsp_pins_t;
  typedef enum logic [2:0] {
    DSP_OP_IDLE = 3'b001,
    DSP_OP_WRITE = 3'b010,
    DSP_OP_RMW = 3'b100
  } dsp_op_e;
endpackage

// ==== hw/dsp_sync.sv ====
/*
  two-flop synchroniser for a six-bit pin group.
  assumes one clock; pins are asynchronous to it.
*/
`timescale 1ns/100ps
module dsp_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [5:0] pins_async,
  output logic [5:0] pins_sync
);
  logic [5:0] stage_one;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage_one <= 6'h00;
      pins_sync <= 6'h00;
    end else begin
      stage_one <= pins_async;
      pins_sync <= stage_one;
    end
  end
endmodule

// ==== hw/dsp_port_lane.sv ====
/*
  one port group: output latch and direction latch, six pins.
  assumes core write strobes are single-cycle and on the same clock.
*/
`timescale 1ns/100ps
`include "dsp_io_defs.svh"
module dsp_port_lane (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic data_we,
  input wire logic [5:0] data_in,
  input wire logic dir_we,
  input wire logic [5:0] dir_in,
  output logic [5:0] data_latch,
  output logic [5:0] dir_latch
);
  // latch only changes on a write; a bit set/clear writes pin levels into it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      data_latch <= 6'h00;
    end else if (data_we) begin
      data_latch <= data_in;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dir_latch <= `DSP_DIR_RESET;
    end else if (dir_we) begin
      dir_latch <= dir_in;
    end
  end
endmodule

// ==== sim/dsp_io_monitor.sv ====
/*
  checker for the dual six-bit port: read, drive, pull-up and reset relations.
  assumes bind onto dsp_io_port, one clock domain.
*/
`timescale 1ns/100ps
module dsp_io_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wake_reset_cause,
  input wire logic [4:0] reg_addr,
  input wire logic reg_read,
  input wire logic dir_load,
  input wire logic [2:0] dir_port_sel,
  input wire logic [7:0] work_reg,
  input wire logic external_reset_enable,
  input wire logic [5:0] group_b_alt_analog,
  input wire logic [5:0] group_b_alt_comp,
  input wire logic [5:0] group_c_alt_analog,
  input wire logic [5:0] group_c_alt_out_en,
  input wire logic [5:0] group_c_pin_bits_in,
  input wire logic [5:0] group_b_pin_bits_oe_n,
  input wire logic [5:0] group_c_pin_bits_oe_n,
  input wire logic [5:0] group_b_pull_up,
  input wire logic [7:0] reg_rdata,
  input wire logic pin_wake_flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  sequence s_rd_port;
    reg_read && (reg_addr == 5'h06 || reg_addr == 5'h07);
  endsequence
  sequence s_alt_c_off;
    group_c_alt_analog == 6'h00 && group_c_alt_out_en == 6'h00;
  endsequence
  // pins must sit still long enough to clear the synchroniser
  sequence s_quiet_c;
    $stable(group_c_pin_bits_in) [*3] ##0 reg_read && reg_addr == 5'h07 ##0 s_alt_c_off;
  endsequence
  sequence s_dir_c;
    dir_load && dir_port_sel == 3'h7 ##0 s_alt_c_off;
  endsequence
  ////////////////////////////////////////
  a_read_live_pins: assert property (
    s_quiet_c |=> reg_rdata == {2'b00, $past(group_c_pin_bits_in)}) else $error("port read not live pins");
  a_reset_all_inputs: assert property (
    $rose(reset_n) |-> group_b_pin_bits_oe_n == 6'h3f && group_c_pin_bits_oe_n == 6'h3f)
    else $error("pins driven after reset");
  a_port_upper_zero: assert property (
    s_rd_port |=> reg_rdata[7:6] == 2'b00) else $error("port upper bits set");
  a_input_only_float: assert property (
    group_b_pin_bits_oe_n[3]) else $error("input-only pin driven");
  a_alt_reads_zero: assert property (
    reg_read && reg_addr == 5'h06 |=> (reg_rdata[5:0] & $past(group_b_alt_analog | group_b_alt_comp)) == 6'h00)
    else $error("alternate pin read nonzero");
  a_pull_pins_only: assert property (
    (group_b_pull_up & 6'h24) == 6'h00) else $error("pull-up on incapable pin");
  a_pull_global: assert property (
    group_b_pull_up[0] == group_b_pull_up[1] && group_b_pull_up[1] == group_b_pull_up[4])
    else $error("pull-up not global");
  a_reset_pin_pull: assert property (
    external_reset_enable [*3] |-> group_b_pull_up[3]) else $error("reset pin pull-up off");
  a_dir_drives: assert property (
    s_dir_c |-> ##2 group_c_pin_bits_oe_n[4:0] == $past(work_reg[4:0], 2)) else $error("direction not applied");
  a_status_read: assert property (
    reg_read && reg_addr == 5'h03 |=> reg_rdata == {$past(pin_wake_flag), 7'h00}) else $error("status read wrong");
  a_wake_flag_cause: assert property (
    $rose(reset_n) |=> pin_wake_flag == $past(wake_reset_cause)) else $error("wake flag not cause");
endmodule

// ==== sim/dsp_pin_model.sv ====
/*
  outside world of one six-bit pin group: block drive, external drive, pull, float.
  assumes oe_n low means the block drives the pin.
*/
`timescale 1ns/100ps
module dsp_pin_model (
  input wire logic clock,
  input wire logic [5:0] oe_n,
  input wire logic [5:0] drive,
  input wire logic [5:0] pull_up,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] pins
);
  logic [5:0] wander = 6'h15;
  // a floating line never holds a stale level
  always @(posedge clock) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!oe_n[i]) pins[i] = drive[i];
      else if (ext_en[i]) pins[i] = ext_val[i];
      else pins[i] = pull_up[i] ? 1'b1 : wander[i];
    end
  end
endmodule

// ==== sim/testbench.sv ====
/*
  self-checking bench for dsp_io_port driven through its core strobes.
  assumes dsp_pin_model stands at both pin groups.
*/
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic wake_reset_cause = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_read = 1'b0, reg_write = 1'b0, bit_op = 1'b0, bit_value = 1'b0;
  logic dir_load = 1'b0, option_load = 1'b0, external_reset_enable = 1'b0;
  logic [7:0] reg_wdata = 8'h00, work_reg = 8'h00, rd;
  logic [7:0] reg_rdata;
  logic [2:0] bit_index = 3'h0, dir_port_sel = 3'h0;
  logic [5:0] group_b_alt_analog = 6'h00, group_b_alt_comp = 6'h00, group_b_alt_out_en = 6'h00;
  logic [5:0] group_b_alt_out = 6'h00, group_c_alt_analog = 6'h00, group_c_alt_out_en = 6'h00;
  logic [5:0] group_c_alt_out = 6'h00, b_ext_val = 6'h00;
  wire logic [5:0] group_b_pin_bits_in, group_c_pin_bits_in;
  logic [5:0] group_b_pin_bits_out, group_b_pin_bits_oe_n, group_c_pin_bits_out, group_c_pin_bits_oe_n;
  logic [5:0] group_b_pull_up;
  logic pin_wake_event, pin_wake_flag;
  int miscompares = 0, cmp_count = 0;
  always #5 clock = ~clock;
  dsp_io_port dut (
    .clock(clock),
    .reset_n(reset_n),
    .wake_reset_cause(wake_reset_cause),
    .reg_addr(reg_addr),
    .reg_read(reg_read),
    .reg_write(reg_write),
    .reg_wdata(reg_wdata),
    .bit_op(bit_op),
    .bit_value(bit_value),
    .bit_index(bit_index),
    .dir_load(dir_load),
    .dir_port_sel(dir_port_sel),
    .option_load(option_load),
    .work_reg(work_reg),
    .external_reset_enable(external_reset_enable),
    .group_b_alt_analog(group_b_alt_analog),
    .group_b_alt_comp(group_b_alt_comp),
    .group_b_alt_out_en(group_b_alt_out_en),
    .group_b_alt_out(group_b_alt_out),
    .group_c_alt_analog(group_c_alt_analog),
    .group_c_alt_out_en(group_c_alt_out_en),
    .group_c_alt_out(group_c_alt_out),
    .group_b_pin_bits_in(group_b_pin_bits_in),
    .group_c_pin_bits_in(group_c_pin_bits_in),
    .group_b_pin_bits_out(group_b_pin_bits_out),
    .group_b_pin_bits_oe_n(group_b_pin_bits_oe_n),
    .group_c_pin_bits_out(group_c_pin_bits_out),
    .group_c_pin_bits_oe_n(group_c_pin_bits_oe_n),
    .group_b_pull_up(group_b_pull_up),
    .pin_wake_event(pin_wake_event),
    .reg_rdata(reg_rdata),
    .pin_wake_flag(pin_wake_flag)
  );
  dsp_pin_model pins_b (.clock(clock), .oe_n(group_b_pin_bits_oe_n), .drive(group_b_pin_bits_out),
    .pull_up(group_b_pull_up), .ext_en(6'h3f), .ext_val(b_ext_val), .pins(group_b_pin_bits_in));
  dsp_pin_model pins_c (.clock(clock), .oe_n(group_c_pin_bits_oe_n), .drive(group_c_pin_bits_out),
    .pull_up(6'h00), .ext_en(6'h00), .ext_val(6'h00), .pins(group_c_pin_bits_in));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
    tick(1);
  endtask
  task automatic reg_rd(input logic [4:0] a);
    reg_addr = a;
    reg_read = 1'b1;
    tick(1);
    reg_read = 1'b0;
    rd = reg_rdata;
    tick(1);
  endtask
  task automatic instr(input logic opt, input logic [2:0] sel, input logic [7:0] w);
    dir_port_sel = sel;
    work_reg = w;
    dir_load = !opt;
    option_load = opt;
    tick(1);
    dir_load = 1'b0;
    option_load = 1'b0;
    tick(1);
  endtask
  task automatic do_reset(input logic cause);
    reset_n = 1'b0;
    wake_reset_cause = cause;
    tick(6);
    reset_n = 1'b1;
    tick(1);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    do_reset(1'b1);
    check("oe b", {2'b00, group_b_pin_bits_oe_n}, 8'h3f);
    check("oe c", {2'b00, group_c_pin_bits_oe_n}, 8'h3f);
    check("flag wake", {7'h00, pin_wake_flag}, 8'h01);
    reg_rd(5'h03);
    check("status wake", rd, 8'h80);
    do_reset(1'b0);
    check("flag other", {7'h00, pin_wake_flag}, 8'h00);
    reg_rd(5'h03);
    check("status other", rd, 8'h00);
    // timer pin stays input until option releases it
    reg_wr(5'h07, 8'hea);
    instr(1'b0, 3'h7, 8'h00);
    check("c oe timer", {2'b00, group_c_pin_bits_oe_n}, 8'h20);
    check("c out", {3'b000, group_c_pin_bits_out[4:0]}, 8'h0a);
    instr(1'b1, 3'h0, 8'hdf);
    check("c oe free", {2'b00, group_c_pin_bits_oe_n}, 8'h00);
    // pins settle through the synchroniser before the read
    tick(3);
    reg_rd(5'h07);
    check("c read", rd, 8'h2a);
    group_c_alt_out_en = 6'h01;
    group_c_alt_out = 6'h01;
    tick(2);
    check("c alt out", {7'h00, group_c_pin_bits_out[0]}, 8'h01);
    group_c_alt_out_en = 6'h00;
    // bit clear copies live input levels into the whole latch
    b_ext_val = 6'h15;
    tick(4);
    bit_op = 1'b1;
    bit_index = 3'h0;
    bit_value = 1'b0;
    reg_wr(5'h06, 8'h00);
    bit_op = 1'b0;
    instr(1'b0, 3'h6, 8'h00);
    check("b out rmw", {2'b00, group_b_pin_bits_out}, 8'h14);
    check("b oe", {2'b00, group_b_pin_bits_oe_n}, 8'h08);
    check("c held", {2'b00, group_c_pin_bits_out}, 8'h2a);
    group_b_alt_analog = 6'h10;
    group_b_alt_comp = 6'h04;
    tick(4);
    reg_rd(5'h06);
    check("b alt read", rd, 8'h00);
    check("b analog float", {2'b00, group_b_pin_bits_oe_n}, 8'h18);
    group_b_alt_analog = 6'h00;
    group_b_alt_comp = 6'h00;
    instr(1'b1, 3'h0, 8'hbf);
    tick(1);
    check("pull all", {2'b00, group_b_pull_up}, 8'h1b);
    external_reset_enable = 1'b1;
    instr(1'b1, 3'h0, 8'hff);
    tick(1);
    check("pull reset pin", {2'b00, group_b_pull_up}, 8'h08);
    external_reset_enable = 1'b0;
    // wake reference is the last read of group b
    instr(1'b0, 3'h6, 8'h3f);
    instr(1'b1, 3'h0, 8'h7f);
    b_ext_val = 6'h00;
    tick(4);
    reg_rd(5'h06);
    b_ext_val = 6'h04;
    tick(4);
    check("no wake", {7'h00, pin_wake_event}, 8'h00);
    b_ext_val = 6'h14;
    for (int i = 0; i < 8 && pin_wake_event !== 1'b1; i++) tick(1);
    check("wake", {7'h00, pin_wake_event}, 8'h01);
    reg_wr(5'h05, 8'hff);
    reg_rd(5'h05);
    check("unmapped", rd, 8'h00);
    test_done();
  end
endmodule
bind dsp_io_port dsp_io_monitor u_mon (
  .clock(clock),
  .reset_n(reset_n),
  .wake_reset_cause(wake_reset_cause),
  .reg_addr(reg_addr),
  .reg_read(reg_read),
  .dir_load(dir_load),
  .dir_port_sel(dir_port_sel),
  .work_reg(work_reg),
  .external_reset_enable(external_reset_enable),
  .group_b_alt_analog(group_b_alt_analog),
  .group_b_alt_comp(group_b_alt_comp),
  .group_c_alt_analog(group_c_alt_analog),
  .group_c_alt_out_en(group_c_alt_out_en),
  .group_c_pin_bits_in(group_c_pin_bits_in),
  .group_b_pin_bits_oe_n(group_b_pin_bits_oe_n),
  .group_c_pin_bits_oe_n(group_c_pin_bits_oe_n),
  .group_b_pull_up(group_b_pull_up),
  .reg_rdata(reg_rdata),
  .pin_wake_flag(pin_wake_flag)
);
